// ===== shared/sfb_pkg.sv
package sfb_pkg;
  // ------------------------------------------------------------
  // instruction codes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_DTR_QIO = 8'hed;
  localparam logic [7:0] OP_ENTER_QPI = 8'h38;
  localparam logic [7:0] OP_EXIT_QPI = 8'hff;
  localparam logic [7:0] OP_EN_RESET = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_QPROG = 8'h32;
  localparam logic [7:0] OP_SECT_ERASE = 8'h20;
  localparam logic [7:0] OP_BLK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] OP_RELEASE_PD = 8'hab;
  localparam logic [7:0] OP_UNLOCK = 8'h39;

  // ------------------------------------------------------------
  // geometry and timing
  // ------------------------------------------------------------
  localparam int LOCK_BLOCKS = 30;
  localparam int LOCK_SECTORS = 32;
  localparam int LOCK_BITS = LOCK_BLOCKS + LOCK_SECTORS;
  localparam int SYS_CLK_MHZ = 100;
  localparam int SW_RESET_US = 30;
  localparam int RESET_PULSE_MIN_NS = 1000;
  localparam int SW_RESET_CYC = SW_RESET_US * SYS_CLK_MHZ;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int POWERUP_DELAY_US = 5000;
  localparam int POWERUP_DELAY_CYC = POWERUP_DELAY_US * SYS_CLK_MHZ;
  localparam int INSTR_BITS = 8;
  localparam int QPI_INSTR_CLKS = 2;
  localparam int ADDR_BITS = 24;
  localparam logic [1:0] STRAP_PAUSE = 2'h0;
endpackage

// ===== rtl/sfb_front_end.sv
`timescale 1ns/100ps
// Operation
// - single line: sample input on rising clock, drive output on falling clock.
// - modes 0 and 3 accepted; host parks clock at select edges.
// - dual instructions use lines zero and one bidirectionally.
// - quad instructions use four lines; need quad enable (not checked here: quad opcodes run with it clear).
// - serial or four-line mode only; 38h enters, FFh leaves, reset exits.
// - four-line mode takes instruction in two clocks, serial in eight.
// - four-line mode entry only with quad enable already set.
// - enter command with quad enable clear is ignored.
// - double-rate: instruction on rising, then address and data both edges.
// - pause only with quad enable clear; otherwise pin is line three.
// - pause starts at pause fall if clock low, else next clock fall.
// - pause ends at pause rise if clock low, else next clock fall.
// - while paused: output off, input and clock ignored, state kept.
// - 66h then 99h resets; about 30 us busy, commands refused.
// - pin-role bit: zero pause input, one active-low reset input.
// - reset low restores power-on state, aborts work, refuses commands.
// - hardware reset overrides all inputs; host holds it at least 1 us.
// - dedicated reset pin ignores quad enable and pin-role bit.
// - after power-up, write-related instructions refused for a fixed delay.
// - write latch clear at power-up; needed for writes; cleared on completion.
// - in power-down only the release instruction is obeyed.
// - 62 lock bits set at power-on; locked regions refuse; 39h unlocks one.
// - scheme bit picks status protection or individual locks.
module sfb_front_end #(
  parameter int SwResetCyc = sfb_pkg::SW_RESET_CYC,
  parameter int PowerUpCyc = sfb_pkg::POWERUP_DELAY_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic serialClk,
  input wire logic chipSel_n,
  input wire logic dataLineZeroIn,
  output logic dataLineZeroOut,
  output logic dataLineZeroOe,
  input wire logic dataLineOneIn,
  output logic dataLineOneOut,
  output logic dataLineOneOe,
  input wire logic dataLineTwoIn,
  output logic dataLineTwoOut,
  output logic dataLineTwoOe,
  input wire logic dataLineThreeIn,
  output logic dataLineThreeOut,
  output logic dataLineThreeOe,
  input wire logic dedicatedReset_n,
  input wire logic supplyGood,
  input wire logic quadEnableBit,
  input wire logic pinRoleReset,
  input wire logic protectSchemeSelect,
  input wire logic statusAreaProtected,
  input wire logic opDone,
  input wire logic [7:0] readData,
  output logic readDataTake,
  output logic [7:0] opCode,
  output logic [sfb_pkg::ADDR_BITS-1:0] opAddr,
  output logic opStrobe,
  output logic writeEnableLatch,
  output logic fourLineMode,
  output logic paused,
  output logic powerDown,
  output logic resetBusy,
  output logic writeAllowed,
  output logic [sfb_pkg::LOCK_BITS-1:0] lockBits
);
  import sfb_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers: change counts once stages two and three agree
  // ------------------------------------------------------------
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pinRaw;
  logic [NSYNC-1:0] syncA, syncB, syncC, pinStable_r;
  // every data line is synchronised too, so lines sampled together stay aligned with the clock
  assign pinRaw = {dataLineTwoIn, dataLineOneIn, dedicatedReset_n, dataLineThreeIn, dataLineZeroIn,
                   chipSel_n, serialClk};
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= '1;
      syncB <= '1;
      syncC <= '1;
      pinStable_r <= '1;
    end else begin
      syncA <= pinRaw;
      syncB <= syncA;
      syncC <= syncB;
      pinStable_r <= pinStable_r;
      for (int i = 0; i < NSYNC; i++) begin
        if (syncB[i] == syncC[i]) pinStable_r[i] <= syncC[i];
      end
    end
  end
  logic sClk, csn, din, line1, line2, line3, dedRstn;
  assign {line2, line1, dedRstn, line3, din, csn, sClk} = pinStable_r;
  logic sClk_r, csn_r, line3_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sClk_r <= 1'b1;
      csn_r <= 1'b1;
      line3_r <= 1'b1;
    end else begin
      sClk_r <= sClk;
      csn_r <= csn;
      line3_r <= line3;
    end
  end

  // ------------------------------------------------------------
  // reset sources and pause
  // ------------------------------------------------------------
  // shared pin is reset only with quad enable clear and role bit set
  wire sharedIsReset = !quadEnableBit && pinRoleReset;
  wire pauseAllowed = !quadEnableBit && !pinRoleReset;
  wire hwReset = !dedRstn || (sharedIsReset && !line3);
  wire sClkRise = sClk && !sClk_r;
  wire sClkFall = !sClk && sClk_r;
  wire selected = !csn;
  logic pause_r;
  // pause follows the pin directly when clock is low, else waits a clock fall
  wire pauseWant = pauseAllowed && selected && !line3;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) pause_r <= 1'b0;
    else if (hwReset || !selected || !pauseAllowed) pause_r <= 1'b0;
    else if (pauseWant != pause_r && (!sClk || sClkFall)) pause_r <= pauseWant;
  end
  assign paused = pause_r;

  // ------------------------------------------------------------
  // power-up delay and software reset busy counters
  // ------------------------------------------------------------
  logic [31:0] puCnt_r, srCnt_r;
  wire puDone = (puCnt_r == 32'h0);
  logic swResetGo;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      puCnt_r <= 32'(PowerUpCyc);
      srCnt_r <= 32'h0;
    end else begin
      if (!supplyGood) puCnt_r <= 32'(PowerUpCyc);
      else if (!puDone) puCnt_r <= puCnt_r - 32'h1;
      if (swResetGo) srCnt_r <= 32'(SwResetCyc);
      else if (srCnt_r != 32'h0) srCnt_r <= srCnt_r - 32'h1;
    end
  end
  assign resetBusy = (srCnt_r != 32'h0) || hwReset;
  // any of these wipes instruction and mode state
  wire stateClear = hwReset || !supplyGood || swResetGo;

  // ------------------------------------------------------------
  // instruction sequencer
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    SFB_IDLE = 4'b0001,
    SFB_OPC = 4'b0010,
    SFB_ADDR = 4'b0100,
    SFB_DATA = 4'b1000
  } sfb_state_e;
  sfb_state_e st_r, st_nxt;
  logic [7:0] shift_r;
  logic [5:0] bitCnt_r;
  logic [7:0] op_r;
  logic [ADDR_BITS-1:0] addr_r;
  logic qpi_r, wel_r, pd_r, rstArm_r, dtr_r;
  logic [1:0] width_r; // 0 single, 1 dual, 2 quad
  logic [7:0] out_r;

  // line width after the opcode is known
  function automatic logic [1:0] op_width(input logic [7:0] op, input logic four_line_instruction_mode);
    if (four_line_instruction_mode) return 2'h2;
    else if (op == OP_QUAD_OUT || op == OP_QUAD_IO || op == OP_DTR_QIO) return 2'h2;
    else if (op == OP_DUAL_OUT || op == OP_DUAL_IO) return 2'h1;
    else return 2'h0;
  endfunction
  function automatic logic is_write_op(input logic [7:0] op);
    return op == OP_PROG || op == OP_QPROG || op == OP_SECT_ERASE ||
      op == OP_BLK_ERASE || op == OP_CHIP_ERASE || op == OP_WRSR || op == OP_UNLOCK;
  endfunction

  wire [3:0] lineIn = {line3, line2, line1, din};
  wire active = selected && !pause_r && !resetBusy && puCnt_r != PowerUpCyc;
  // opcode only on rising edges; double-rate address falls only after its first rise
  wire dtrFall = dtr_r && st_r == SFB_ADDR && bitCnt_r != 6'h0 && sClkFall;
  wire capEdge = active && (sClkRise || dtrFall);
  wire [1:0] inW = (st_r == SFB_OPC) ? (qpi_r ? 2'h2 : 2'h0) : width_r;
  wire [7:0] shiftNxt = (inW == 2'h2) ? {shift_r[3:0], lineIn} :
                        (inW == 2'h1) ? {shift_r[5:0], lineIn[1:0]} : {shift_r[6:0], din};
  // address gathers whole, at the line width in use
  wire [ADDR_BITS-1:0] addrNxt = (inW == 2'h2) ? {addr_r[ADDR_BITS-5:0], lineIn} :
                                 (inW == 2'h1) ? {addr_r[ADDR_BITS-3:0], lineIn[1:0]} :
                                 {addr_r[ADDR_BITS-2:0], din};
  wire [5:0] step = (inW == 2'h2) ? 6'h4 : (inW == 2'h1) ? 6'h2 : 6'h1;
  wire [5:0] bitNxt = bitCnt_r + step;
  wire opcDone = st_r == SFB_OPC && capEdge && bitNxt == 6'(INSTR_BITS);
  // the opcode, not the mode, decides whether an address follows
  wire needsAddr = op_width(shiftNxt, 1'b0) != 2'h0 || is_write_op(shiftNxt);
  wire opAccept = opcDone && (!pd_r || shiftNxt == OP_RELEASE_PD);
  wire writeOk = puDone && wel_r;
  assign swResetGo = opAccept && rstArm_r && shiftNxt == OP_RESET;

  // next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      SFB_IDLE: if (active && csn_r) st_nxt = SFB_OPC;
      SFB_OPC: if (opcDone) st_nxt = (opAccept && needsAddr) ? SFB_ADDR : SFB_DATA;
      SFB_ADDR: if (capEdge && bitNxt == 6'(ADDR_BITS)) st_nxt = SFB_DATA;
      SFB_DATA: st_nxt = SFB_DATA;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= SFB_IDLE;
      shift_r <= 8'h0;
      bitCnt_r <= 6'h0;
      op_r <= 8'h0;
      addr_r <= '0;
      width_r <= 2'h0;
      dtr_r <= 1'b0;
    end else if (stateClear || csn) begin
      st_r <= SFB_IDLE;
      bitCnt_r <= 6'h0;
      dtr_r <= 1'b0;
      width_r <= 2'h0;
    end else begin
      st_r <= (st_r == SFB_IDLE && !csn_r) ? SFB_OPC : st_nxt;
      if (capEdge && st_r != SFB_DATA) begin
        shift_r <= shiftNxt;
        bitCnt_r <= (opcDone || st_nxt == SFB_DATA) ? 6'h0 : bitNxt;
        if (st_r == SFB_ADDR) addr_r <= addrNxt;
      end
      if (opcDone) begin
        op_r <= shiftNxt;
        width_r <= op_width(shiftNxt, qpi_r);
        dtr_r <= shiftNxt == OP_DTR_QIO;
      end
    end
  end

  // ------------------------------------------------------------
  // mode, latch, power-down and reset arming
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      qpi_r <= 1'b0;
      wel_r <= 1'b0;
      pd_r <= 1'b0;
      rstArm_r <= 1'b0;
    end else if (stateClear) begin
      qpi_r <= 1'b0;
      wel_r <= 1'b0;
      pd_r <= 1'b0;
      rstArm_r <= 1'b0;
    end else begin
      if (opDone) wel_r <= 1'b0;
      if (opAccept) begin
        rstArm_r <= shiftNxt == OP_EN_RESET;
        if (shiftNxt == OP_ENTER_QPI && quadEnableBit) qpi_r <= 1'b1;
        if (shiftNxt == OP_EXIT_QPI) qpi_r <= 1'b0;
        if (shiftNxt == OP_WREN && puDone) wel_r <= 1'b1;
        if (shiftNxt == OP_WRDI) wel_r <= 1'b0;
        if (shiftNxt == OP_POWER_DOWN) pd_r <= 1'b1;
        if (shiftNxt == OP_RELEASE_PD) pd_r <= 1'b0;
      end
    end
  end
  assign writeEnableLatch = wel_r;
  assign fourLineMode = qpi_r;
  assign powerDown = pd_r;
  assign writeAllowed = writeOk;

  // ------------------------------------------------------------
  // individual locks: all set at power-on, unlock by 39h
  // ------------------------------------------------------------
  wire addrDone = st_r == SFB_ADDR && st_nxt == SFB_DATA;
  wire [ADDR_BITS-1:0] addrFull = addrNxt;
  wire [4:0] blockIdx = addrFull[20:16];
  wire edgeBlock = blockIdx == 5'h0 || blockIdx == 5'h1f;
  // top block sectors follow bottom ones in the lock vector
  wire [5:0] lockIdx = edgeBlock ? 6'(LOCK_BLOCKS) + {blockIdx[4], addrFull[15:12]} :
                                   6'(blockIdx - 5'h1);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) lockBits <= '1;
    else if (stateClear) lockBits <= '1;
    else if (addrDone && op_r == OP_UNLOCK && writeOk) lockBits[lockIdx] <= 1'b0;
  end
  // scheme bit picks which protection gates the array write
  wire regionLocked = protectSchemeSelect ? lockBits[lockIdx] : statusAreaProtected;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      opStrobe <= 1'b0;
      opCode <= 8'h0;
      opAddr <= '0;
    end else begin
      opStrobe <= 1'b0;
      if (addrDone && op_r != OP_UNLOCK && (!is_write_op(op_r) || (writeOk && !regionLocked))) begin
        opStrobe <= 1'b1;
        opCode <= op_r;
        opAddr <= addrFull;
      end else if (opAccept && !needsAddr) begin
        opStrobe <= 1'b1;
        opCode <= shiftNxt;
      end
    end
  end

  // ------------------------------------------------------------
  // read data out: shifted on falling clock (both edges in double-rate), off while paused
  // ------------------------------------------------------------
  logic [3:0] oe_r;
  wire outEdge = active && st_r == SFB_DATA && (sClkFall || (dtr_r && sClkRise));
  logic [5:0] outCnt_r;
  // one fetch per byte, at the edge that starts it
  wire outLoad = outEdge && outCnt_r == 6'h0;
  assign readDataTake = outLoad;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= 8'h0;
      oe_r <= 4'h0;
      outCnt_r <= 6'h0;
    end else if (csn || stateClear) begin
      oe_r <= 4'h0;
      outCnt_r <= 6'h0;
    end else if (pause_r) begin
      oe_r <= 4'h0;
    end else if (outEdge) begin
      out_r <= (outCnt_r == 6'h0) ? readData : (width_r == 2'h2) ? {out_r[3:0], 4'h0} :
               (width_r == 2'h1) ? {out_r[5:0], 2'h0} : {out_r[6:0], 1'b0};
      outCnt_r <= (outCnt_r + step >= 6'(INSTR_BITS)) ? 6'h0 : outCnt_r + step;
      oe_r <= (width_r == 2'h2) ? 4'hf : (width_r == 2'h1) ? 4'h3 : 4'h2;
    end
  end
  wire [7:0] outVal = out_r;
  assign dataLineZeroOut = (width_r == 2'h0) ? 1'b0 : (width_r == 2'h1) ? outVal[6] : outVal[4];
  assign dataLineOneOut = (width_r == 2'h0) ? outVal[7] : (width_r == 2'h1) ? outVal[7] : outVal[5];
  assign dataLineTwoOut = outVal[6];
  assign dataLineThreeOut = outVal[7];
  assign {dataLineThreeOe, dataLineTwoOe, dataLineOneOe, dataLineZeroOe} = oe_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_qpi_needs_qe: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(qpi_r) |-> quadEnableBit) else $error("four-line mode entered without quad enable");
  a_pause_tristate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pause_r |=> oe_r == 4'h0) else $error("output driven while paused");
  a_pause_qe_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    quadEnableBit |-> ##1 !pause_r) else $error("pause with quad enable set");
  a_wel_needs_pu: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(wel_r) |-> $past(puDone)) else $error("write latch set during power-up delay");
  a_swreset_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    swResetGo |=> !qpi_r && resetBusy) else $error("software reset incomplete");
  a_hwreset_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hwReset |=> !qpi_r && !wel_r && st_r == SFB_IDLE) else $error("hardware reset ignored");
  a_cs_discard: assert property (@(posedge sys_clk) disable iff (!rst_n)
    csn |=> st_r == SFB_IDLE) else $error("instruction kept after select release");
  a_pd_only_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pd_r && opcDone && shiftNxt != OP_RELEASE_PD |=> !opStrobe) else $error("command in power-down");
endmodule

// ===== verification/sfb_host_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// host controller model: mode 0 framing, 80 ns serial clock
// ------------------------------------------------------------
module sfb_host_model (
  input wire logic sys_clk,
  output logic serialClk,
  output logic chipSel_n,
  output logic [3:0] lineIn,
  input wire logic [3:0] devOut,
  input wire logic [3:0] devOe
);
  logic [3:0] hostVal = 4'hd;
  logic [3:0] hostOe = 4'hd;
  logic [3:0] lastLvl = 4'h0;

  // clock parked low and select high outside frames
  initial begin
    serialClk = 1'b0;
    chipSel_n = 1'b1;
  end

  // a released line toggles, so a stale level is never mistaken for data
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lineIn[i] = devOe[i] ? devOut[i] : (hostOe[i] ? hostVal[i] : ~lastLvl[i]);
    end
  end

  // last wire level, for the released-line pattern
  always @(posedge sys_clk) begin
    lastLvl <= lineIn;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // open and close let one frame be split around a pause or cut short
  task automatic frame(input logic [31:0] bits, input int nClk, input logic quad,
                       input logic open, input logic close);
    if (open) begin
      chipSel_n = 1'b0;
      tick(4);
    end
    for (int i = 0; i < nClk; i++) begin
      if (quad) begin
        hostOe = 4'hf;
        hostVal = bits[31-4*i -: 4];
      end else begin
        hostVal[0] = bits[31-i];
      end
      tick(4);
      serialClk = 1'b1;
      tick(4);
      serialClk = 1'b0;
    end
    if (close) begin
      tick(4);
      chipSel_n = 1'b1;
      hostOe = 4'hd;
      hostVal = 4'hd;
      tick(12);
    end
  endtask

  // select is left alone, so a pause never drops the frame
  task automatic set_line3(input logic lvl);
    hostVal[3] = lvl;
  endtask
endmodule

// ===== verification/sfb_front_end_bench.sv
`timescale 1ns/100ps
module sfb_front_end_bench;
  import sfb_pkg::*;
  // short counts keep the run brief; expectations follow these values
  localparam int SwCyc = 60;
  localparam int PupCyc = 200;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic dedicatedReset_n = 1'b1;
  logic supplyGood = 1'b1;
  logic quadEnableBit = 1'b0;
  logic pinRoleReset = 1'b0;
  logic protectSchemeSelect = 1'b0;
  logic opDone = 1'b0;
  logic statusProt = 1'b0;
  logic [7:0] rdByte = 8'ha5;
  wire serialClk;
  wire chipSel_n;
  wire [3:0] lineIn;
  wire [3:0] devOut;
  wire [3:0] devOe;
  logic readDataTake, opStrobe, writeEnableLatch, fourLineMode, paused, powerDown, resetBusy;
  logic writeAllowed;
  logic [7:0] opCode;
  logic [7:0] lastOp = 8'h00;
  logic [ADDR_BITS-1:0] opAddr;
  logic [LOCK_BITS-1:0] lockBits;
  int strobeCount = 0;
  int n_mismatch = 0;
  int check_count = 0;
  int takeCount = 0;

  always #5 sys_clk = ~sys_clk;

  sfb_host_model host_u (.sys_clk(sys_clk), .serialClk(serialClk), .chipSel_n(chipSel_n),
    .lineIn(lineIn), .devOut(devOut), .devOe(devOe));

  sfb_front_end #(.SwResetCyc(SwCyc), .PowerUpCyc(PupCyc)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .serialClk(serialClk), .chipSel_n(chipSel_n),
    .dataLineZeroIn(lineIn[0]), .dataLineZeroOut(devOut[0]), .dataLineZeroOe(devOe[0]),
    .dataLineOneIn(lineIn[1]), .dataLineOneOut(devOut[1]), .dataLineOneOe(devOe[1]),
    .dataLineTwoIn(lineIn[2]), .dataLineTwoOut(devOut[2]), .dataLineTwoOe(devOe[2]),
    .dataLineThreeIn(lineIn[3]), .dataLineThreeOut(devOut[3]), .dataLineThreeOe(devOe[3]),
    .dedicatedReset_n(dedicatedReset_n), .supplyGood(supplyGood),
    .quadEnableBit(quadEnableBit), .pinRoleReset(pinRoleReset),
    .protectSchemeSelect(protectSchemeSelect), .statusAreaProtected(statusProt),
    .opDone(opDone), .readData(rdByte), .readDataTake(readDataTake), .opCode(opCode),
    .opAddr(opAddr), .opStrobe(opStrobe), .writeEnableLatch(writeEnableLatch),
    .fourLineMode(fourLineMode), .paused(paused), .powerDown(powerDown),
    .resetBusy(resetBusy), .writeAllowed(writeAllowed), .lockBits(lockBits));

  // strobe is one cycle wide, so it is caught here rather than polled
  always @(posedge sys_clk) begin
    if (opStrobe === 1'b1) begin
      strobeCount <= strobeCount + 1;
      lastOp <= opCode;
    end
    if (readDataTake === 1'b1) takeCount <= takeCount + 1;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic op(input logic [7:0] code, input logic quad);
    host_u.frame({code, 24'h0}, quad ? 2 : 8, quad, 1'b1, 1'b1);
  endtask

  task automatic final_report;
    $display("compares %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_mismatch++;
    final_report();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int s;
    tick(4);
    rst_n = 1'b1;
    tick(2);
    check({writeEnableLatch, fourLineMode, paused, powerDown, resetBusy}, 0);
    check(lockBits, {LOCK_BITS{1'b1}});
    op(OP_WREN, 1'b0);
    check(writeEnableLatch, 0);
    tick(PupCyc);
    op(OP_WREN, 1'b0);
    check({lastOp, writeEnableLatch}, {OP_WREN, 1'b1});
    opDone = 1'b1;
    tick(1);
    opDone = 1'b0;
    tick(2);
    check(writeEnableLatch, 0);
    s = strobeCount;
    host_u.frame({OP_WREN, 24'h0}, 4, 1'b0, 1'b1, 1'b1);
    check(strobeCount - s, 0);
    op(OP_WREN, 1'b0);
    check(writeEnableLatch, 1);
    op(OP_WRDI, 1'b0);
    check(writeEnableLatch, 0);
    $display("test latch and framing done");
    op(OP_ENTER_QPI, 1'b0);
    check(fourLineMode, 0);
    quadEnableBit = 1'b1;
    op(OP_ENTER_QPI, 1'b0);
    check(fourLineMode, 1);
    op(OP_WREN, 1'b1);
    check({lastOp, writeEnableLatch}, {OP_WREN, 1'b1});
    op(OP_EXIT_QPI, 1'b1);
    check(fourLineMode, 0);
    op(OP_ENTER_QPI, 1'b0);
    op(OP_EN_RESET, 1'b1);
    op(OP_RESET, 1'b1);
    check(resetBusy, 1);
    tick(SwCyc + 20);
    check({resetBusy, fourLineMode, writeEnableLatch}, 0);
    tick(PupCyc);
    $display("test four-line mode and soft reset done");
    quadEnableBit = 1'b0;
    host_u.frame({OP_WREN, 24'h0}, 4, 1'b0, 1'b1, 1'b0);
    host_u.set_line3(1'b0);
    tick(10);
    check({paused, devOe}, {1'b1, 4'h0});
    host_u.frame(32'hffffffff, 3, 1'b0, 1'b0, 1'b0);
    host_u.set_line3(1'b1);
    tick(10);
    check(paused, 0);
    host_u.frame({OP_WREN[3:0], 28'h0}, 4, 1'b0, 1'b0, 1'b1);
    check({lastOp, writeEnableLatch}, {OP_WREN, 1'b1});
    quadEnableBit = 1'b1;
    host_u.frame(32'h0, 1, 1'b0, 1'b1, 1'b0);
    host_u.set_line3(1'b0);
    tick(10);
    check(paused, 0);
    host_u.frame(32'h0, 0, 1'b0, 1'b0, 1'b1);
    $display("test pause done");
    op(OP_WRDI, 1'b0);
    op(OP_POWER_DOWN, 1'b0);
    check(powerDown, 1);
    op(OP_WREN, 1'b0);
    check({powerDown, writeEnableLatch}, 2'b10);
    op(OP_RELEASE_PD, 1'b0);
    check(powerDown, 0);
    protectSchemeSelect = 1'b1;
    op(OP_WREN, 1'b0);
    host_u.frame({OP_UNLOCK, 24'h010000}, 32, 1'b0, 1'b1, 1'b1);
    check({lockBits[1], lockBits[0]}, 2'b10);
    s = strobeCount;
    host_u.frame({OP_SECT_ERASE, 24'h020000}, 32, 1'b0, 1'b1, 1'b1);
    check(strobeCount - s, 0);
    host_u.frame({OP_SECT_ERASE, 24'h010000}, 32, 1'b0, 1'b1, 1'b1);
    check({strobeCount - s, lastOp, opAddr}, {32'd1, OP_SECT_ERASE, 24'h010000});
    protectSchemeSelect = 1'b0;
    statusProt = 1'b1;
    host_u.frame({OP_SECT_ERASE, 24'h020000}, 32, 1'b0, 1'b1, 1'b1);
    check(strobeCount - s, 1);
    statusProt = 1'b0;
    host_u.frame({OP_SECT_ERASE, 24'h020000}, 32, 1'b0, 1'b1, 1'b1);
    check({strobeCount - s, opAddr}, {32'd2, 24'h020000});
    $display("test power-down and locks done");
    rdByte = 8'h96;
    s = takeCount;
    host_u.frame({OP_DUAL_OUT, 24'h0}, 22, 1'b0, 1'b1, 1'b0);
    tick(10);
    check({devOe, devOut[1:0], takeCount - s}, {4'h3, rdByte[3:2], 32'd1});
    host_u.frame(32'h0, 0, 1'b0, 1'b0, 1'b1);
    s = strobeCount;
    host_u.frame({OP_DTR_QIO, 24'h0}, 11, 1'b0, 1'b1, 1'b1);
    check({strobeCount - s, lastOp}, {32'd1, OP_DTR_QIO});
    $display("test read and double-rate done");
    quadEnableBit = 1'b0;
    pinRoleReset = 1'b1;
    op(OP_WREN, 1'b0);
    host_u.set_line3(1'b0);
    tick(RESET_PULSE_CYC + 20);
    check(writeEnableLatch, 0);
    host_u.set_line3(1'b1);
    tick(10);
    check(lockBits, {LOCK_BITS{1'b1}});
    quadEnableBit = 1'b1;
    pinRoleReset = 1'b0;
    tick(PupCyc);
    op(OP_WREN, 1'b0);
    check(writeEnableLatch, 1);
    dedicatedReset_n = 1'b0;
    tick(RESET_PULSE_CYC + 20);
    check({writeEnableLatch, fourLineMode}, 0);
    dedicatedReset_n = 1'b1;
    tick(10);
    $display("test hardware reset done");
    supplyGood = 1'b0;
    tick(10);
    supplyGood = 1'b1;
    op(OP_WREN, 1'b0);
    check(writeEnableLatch, 0);
    tick(PupCyc);
    op(OP_WREN, 1'b0);
    check(writeEnableLatch, 1);
    $display("test supply delay done");
    final_report();
  end
endmodule
